// file: cap_consts.vh
/*
 * constants for the codec analog power and pll divider register block:
 * register indexes, field positions, reset values and timing figures.
 * assumes an apb slave with 32-bit data, one register per aligned word.
 */
// Summary of operation
// RULE_01: bit 9 switches the main core-supply regulator; resets off.
// RULE_02: bit 8 switches the pll oscillator amplifier; resets off.
// RULE_03: bit 7 powers the ground-reference buffer; set ramps up, clear ramps down.
// RULE_04: software sets headphone or line amp before clearing bit 7.
// RULE_05: software keeps amps on 200-400 ms after clearing bit 7.
// RULE_06: bit 6 picks adc mono (0) or stereo (1) while adc on; resets one.
// RULE_07: bit 5 switches reference bias currents; resets on.
// RULE_08: bit 4 switches headphone amplifiers; resets off.
// RULE_09: bit 3 switches the dac; resets off.
// RULE_10: bit 2 switches capacitor-free headphone mode; resets off.
// RULE_11: bit 0 switches line output amplifiers; resets off.
// RULE_12: divider register is written only before the pll is powered.
// RULE_13: bits 15:11 hold integer divisor, reset 0xA.
// RULE_14: bits 10:0 hold fractional divisor, reset zero, fraction times 2048.
// RULE_15: software targets 180.6336 MHz at 44.1 kHz, else 196.608 MHz.
// RULE_16: pll input is master clock, or half of it when halving set.
// RULE_17: halving divides master clock by two, only while pll powered.
`ifndef CAP_CONSTS_VH
`define CAP_CONSTS_VH

// register indexes as printed; byte address is four times the index
`define CAP_IDX_ANA_POWER 8'h30
`define CAP_IDX_PLL_DIV 8'h32
`define CAP_IDX_CLK_CFG 8'h34
`define CAP_IDX_STATUS 8'h35
`define CAP_ADDR_WIDTH 10

// analog power field positions
`define CAP_BIT_LINE_OUT 0
`define CAP_BIT_ADC_ON 1
`define CAP_BIT_CAPLESS_HP 2
`define CAP_BIT_DAC_ON 3
`define CAP_BIT_HEADPHONE 4
`define CAP_BIT_BIAS 5
`define CAP_BIT_ADC_STEREO 6
`define CAP_BIT_GND_REF 7
`define CAP_BIT_OSC_AMP 8
`define CAP_BIT_CORE_REG 9
`define CAP_ANA_WIDTH 10
`define CAP_ANA_RESET 10'h060

// pll divider fields
`define CAP_INT_MSB 15
`define CAP_INT_LSB 11
`define CAP_FRAC_MSB 10
`define CAP_FRAC_LSB 0
`define CAP_PLL_RESET 16'h5000

// clock config field
`define CAP_BIT_REF_HALVE 3

// ground-reference ramp time
`define CAP_RAMP_TIME_MS 200
`define CAP_CLK_KHZ 125000
`define CAP_RAMP_CYCLES (`CAP_RAMP_TIME_MS * `CAP_CLK_KHZ)

`endif

// file: cap_power_regs.v
/*
 * apb register block: analog power control, pll divider configuration,
 * clock config and status. drives the analog enables as levels.
 * assumes an apb master on CLK_I and a master clock pin from outside.
 */
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
`include "cap_consts.vh"
module cap_power_regs #(
    parameter RAMP_CYCLES = `CAP_RAMP_CYCLES
) (
    input wire CLK_I,
    input wire RST_N_I,
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [31:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    output wire PREADY_O,
    output reg [31:0] PRDATA_O,
    output wire PSLVERR_O,
    input wire PLL_ON_I,
    input wire MCLK_I,
    output wire MAIN_CORE_REGULATOR_ON_O,
    output wire OSC_AMP_ON_O,
    output wire GROUND_REF_BUFFER_ON_O,
    output wire RAMP_UP_O,
    output wire RAMP_DOWN_O,
    output wire ADC_ON_O,
    output wire ADC_RIGHT_ON_O,
    output wire BIAS_CURRENT_ON_O,
    output wire HEADPHONE_ON_O,
    output wire DAC_ON_O,
    output wire CAPLESS_HP_ON_O,
    output wire LINE_OUT_ON_O,
    output wire [4:0] PLL_INT_PART_O,
    output wire [10:0] PLL_FRACTION_PART_O,
    output wire PLL_REF_CLK_O
);
    reg [`CAP_ANA_WIDTH-1:0] analog_power_ctrl;
    reg [15:0] pll_divider_cfg;
    reg ref_clk_halve;
    reg mclk_meta;
    reg mclk_sync;
    reg gnd_ref_prev;
    reg ramp_busy;
    reg ramp_dir_up;
    reg [31:0] ramp_cnt;
    wire access;
    wire wr_en;
    wire [`CAP_ADDR_WIDTH-1:0] word_addr;
    wire hit_ana;
    wire hit_pll;
    wire hit_clk;
    wire hit_sts;
    wire mapped;
    wire pll_locked_out;

    // byte address of a register from its printed index
    function [`CAP_ADDR_WIDTH-1:0] reg_addr;
        input [7:0] idx;
        begin
            reg_addr = {idx, 2'b00};
        end
    endfunction

    // apb decode; the slave answers in the access cycle with no wait states
    assign access = PSEL_I && PENABLE_I;
    assign wr_en = access && PWRITE_I;
    assign word_addr = PADDR_I[`CAP_ADDR_WIDTH-1:0];
    assign hit_ana = (PADDR_I[31:`CAP_ADDR_WIDTH] == 0) && (word_addr == reg_addr(`CAP_IDX_ANA_POWER));
    assign hit_pll = (PADDR_I[31:`CAP_ADDR_WIDTH] == 0) && (word_addr == reg_addr(`CAP_IDX_PLL_DIV));
    assign hit_clk = (PADDR_I[31:`CAP_ADDR_WIDTH] == 0) && (word_addr == reg_addr(`CAP_IDX_CLK_CFG));
    assign hit_sts = (PADDR_I[31:`CAP_ADDR_WIDTH] == 0) && (word_addr == reg_addr(`CAP_IDX_STATUS));
    assign mapped = hit_ana || hit_pll || hit_clk || hit_sts;
    assign PREADY_O = 1'b1;
    // unmapped addresses, status writes and divider writes while the pll runs are refused
    assign PSLVERR_O = access && (!mapped || (PWRITE_I && hit_sts) || (PWRITE_I && hit_pll && PLL_ON_I));
    assign pll_locked_out = 1'b0;

    // register writes take effect at the access edge
    always @(posedge CLK_I) begin
        if (!RST_N_I) begin
            analog_power_ctrl <= `CAP_ANA_RESET; // [RULE_01] [RULE_02] [RULE_06] [RULE_07]
            pll_divider_cfg <= `CAP_PLL_RESET; // [RULE_13] [RULE_14]
            ref_clk_halve <= 1'b0;
        end else if (wr_en) begin
            if (hit_ana) begin
                analog_power_ctrl <= PWDATA_I[`CAP_ANA_WIDTH-1:0];
            end
            // a divider change under a running pll would unlock it, so it is dropped
            if (hit_pll && !PLL_ON_I) begin // [RULE_12]
                pll_divider_cfg <= PWDATA_I[15:0];
            end
            if (hit_clk) begin
                ref_clk_halve <= PWDATA_I[`CAP_BIT_REF_HALVE];
            end
        end
    end

    // read mux; data registered so it is stable through the access cycle
    always @(posedge CLK_I) begin
        if (!RST_N_I) begin
            PRDATA_O <= 32'h00000000;
        end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
            if (hit_ana) begin
                PRDATA_O <= {22'h000000, analog_power_ctrl};
            end else if (hit_pll) begin
                PRDATA_O <= {16'h0000, pll_divider_cfg};
            end else if (hit_clk) begin
                PRDATA_O <= {28'h0000000, ref_clk_halve, 3'h0};
            end else if (hit_sts) begin
                PRDATA_O <= {29'h00000000, pll_locked_out, ramp_dir_up, ramp_busy};
            end else begin
                PRDATA_O <= 32'h00000000;
            end
        end
    end

    // ground-reference ramp tracker; a toggle mid-ramp restarts in the new direction
    always @(posedge CLK_I) begin
        if (!RST_N_I) begin
            gnd_ref_prev <= 1'b0;
            ramp_busy <= 1'b0;
            ramp_dir_up <= 1'b0;
            ramp_cnt <= 32'h00000000;
        end else begin
            gnd_ref_prev <= analog_power_ctrl[`CAP_BIT_GND_REF];
            if (analog_power_ctrl[`CAP_BIT_GND_REF] != gnd_ref_prev) begin // [RULE_03]
                ramp_busy <= 1'b1;
                ramp_dir_up <= analog_power_ctrl[`CAP_BIT_GND_REF];
                ramp_cnt <= 32'h00000000;
            end else if (ramp_busy) begin
                if (ramp_cnt >= RAMP_CYCLES - 1) begin
                    ramp_busy <= 1'b0;
                end else begin
                    ramp_cnt <= ramp_cnt + 32'h00000001;
                end
            end
        end
    end

    // master clock pin crosses in through two flops before any use
    always @(posedge CLK_I) begin
        if (!RST_N_I) begin
            mclk_meta <= 1'b0;
            mclk_sync <= 1'b0;
        end else begin
            mclk_meta <= MCLK_I;
            mclk_sync <= mclk_meta;
        end
    end

    cap_ref_div u_ref_div (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .mclk_i(mclk_sync),
        .halve_i(ref_clk_halve),
        .pll_on_i(PLL_ON_I),
        .ref_o(PLL_REF_CLK_O)
    );

    // analog enables from the register flops; ramp flags from the ramp tracker, adc right gated by adc on
    assign MAIN_CORE_REGULATOR_ON_O = analog_power_ctrl[`CAP_BIT_CORE_REG]; // [RULE_01]
    assign OSC_AMP_ON_O = analog_power_ctrl[`CAP_BIT_OSC_AMP]; // [RULE_02]
    assign GROUND_REF_BUFFER_ON_O = analog_power_ctrl[`CAP_BIT_GND_REF]; // [RULE_03]
    assign RAMP_UP_O = ramp_busy && ramp_dir_up; // [RULE_03]
    assign RAMP_DOWN_O = ramp_busy && !ramp_dir_up; // [RULE_03]
    assign ADC_ON_O = analog_power_ctrl[`CAP_BIT_ADC_ON];
    // right channel only runs in stereo and only while the adc is on
    assign ADC_RIGHT_ON_O = analog_power_ctrl[`CAP_BIT_ADC_ON] && analog_power_ctrl[`CAP_BIT_ADC_STEREO]; // [RULE_06]
    assign BIAS_CURRENT_ON_O = analog_power_ctrl[`CAP_BIT_BIAS]; // [RULE_07]
    assign HEADPHONE_ON_O = analog_power_ctrl[`CAP_BIT_HEADPHONE]; // [RULE_08]
    assign DAC_ON_O = analog_power_ctrl[`CAP_BIT_DAC_ON]; // [RULE_09]
    assign CAPLESS_HP_ON_O = analog_power_ctrl[`CAP_BIT_CAPLESS_HP]; // [RULE_10]
    assign LINE_OUT_ON_O = analog_power_ctrl[`CAP_BIT_LINE_OUT]; // [RULE_11]
    assign PLL_INT_PART_O = pll_divider_cfg[`CAP_INT_MSB:`CAP_INT_LSB]; // [RULE_13]
    assign PLL_FRACTION_PART_O = pll_divider_cfg[`CAP_FRAC_MSB:`CAP_FRAC_LSB]; // [RULE_14]
endmodule // cap_power_regs

// file: cap_power_regs_props.sv
/* assertions for the analog power and pll divider register block.
   sees only the block's ports; bound to it below. */
`timescale 1ns/100ps
`include "cap_consts.vh"
module cap_power_regs_props (
    input wire CLK_I,
    input wire RST_N_I,
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [31:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    input wire PSLVERR_O,
    input wire PLL_ON_I,
    input wire MAIN_CORE_REGULATOR_ON_O,
    input wire OSC_AMP_ON_O,
    input wire GROUND_REF_BUFFER_ON_O,
    input wire RAMP_UP_O,
    input wire RAMP_DOWN_O,
    input wire ADC_RIGHT_ON_O,
    input wire BIAS_CURRENT_ON_O,
    input wire HEADPHONE_ON_O,
    input wire DAC_ON_O,
    input wire CAPLESS_HP_ON_O,
    input wire LINE_OUT_ON_O,
    input wire [4:0] PLL_INT_PART_O,
    input wire [10:0] PLL_FRACTION_PART_O
);
    localparam [31:0] ANA = `CAP_IDX_ANA_POWER * 4;
    localparam [31:0] PLL = `CAP_IDX_PLL_DIV * 4;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    // completed writes; zero wait states so the access cycle is the taking edge
    wire wr = PSEL_I && PENABLE_I && PWRITE_I;
    wire [15:0] pll = {PLL_INT_PART_O, PLL_FRACTION_PART_O};
    sequence ana_wr; wr && PADDR_I == ANA; endsequence
    sequence pll_wr; wr && PADDR_I == PLL; endsequence
    core_reg_a: assert property (ana_wr |=> MAIN_CORE_REGULATOR_ON_O == $past(PWDATA_I[9]))
        else $error("core regulator enable mismatch");
    osc_amp_a: assert property (ana_wr |=> OSC_AMP_ON_O == $past(PWDATA_I[8]))
        else $error("oscillator amp enable mismatch");
    gnd_ref_a: assert property (ana_wr |=> GROUND_REF_BUFFER_ON_O == $past(PWDATA_I[7]))
        else $error("ground reference enable mismatch");
    adc_right_a: assert property (ana_wr |=> ADC_RIGHT_ON_O == ($past(PWDATA_I[6]) && $past(PWDATA_I[1])))
        else $error("adc right channel mismatch");
    amp_bits_a: assert property (ana_wr |=> {BIAS_CURRENT_ON_O, HEADPHONE_ON_O, DAC_ON_O, CAPLESS_HP_ON_O,
        LINE_OUT_ON_O} == {$past(PWDATA_I[5:2]), $past(PWDATA_I[0])})
        else $error("amplifier enables mismatch");
    ramp_up_a: assert property ($rose(GROUND_REF_BUFFER_ON_O) |-> ##[0:2] RAMP_UP_O)
        else $error("rising ramp did not start");
    ramp_down_a: assert property ($fell(GROUND_REF_BUFFER_ON_O) |-> ##[0:2] RAMP_DOWN_O)
        else $error("falling ramp did not start");
    pll_keep_a: assert property ((pll_wr and PLL_ON_I) |-> PSLVERR_O ##1 $stable(pll))
        else $error("divider changed while pll powered");
    pll_write_a: assert property ((pll_wr and !PLL_ON_I) |=> pll == $past(PWDATA_I[15:0]))
        else $error("divider write not taken");
    reset_val_a: assert property ($rose(RST_N_I) |-> pll == 16'h5000 && BIAS_CURRENT_ON_O && !OSC_AMP_ON_O
        && !MAIN_CORE_REGULATOR_ON_O)
        else $error("reset values wrong");
endmodule // cap_power_regs_props

bind cap_power_regs cap_power_regs_props cap_power_regs_props_inst (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
    .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
    .PSLVERR_O(PSLVERR_O), .PLL_ON_I(PLL_ON_I), .MAIN_CORE_REGULATOR_ON_O(MAIN_CORE_REGULATOR_ON_O),
    .OSC_AMP_ON_O(OSC_AMP_ON_O), .GROUND_REF_BUFFER_ON_O(GROUND_REF_BUFFER_ON_O), .RAMP_UP_O(RAMP_UP_O),
    .RAMP_DOWN_O(RAMP_DOWN_O), .ADC_RIGHT_ON_O(ADC_RIGHT_ON_O), .BIAS_CURRENT_ON_O(BIAS_CURRENT_ON_O),
    .HEADPHONE_ON_O(HEADPHONE_ON_O), .DAC_ON_O(DAC_ON_O), .CAPLESS_HP_ON_O(CAPLESS_HP_ON_O),
    .LINE_OUT_ON_O(LINE_OUT_ON_O), .PLL_INT_PART_O(PLL_INT_PART_O), .PLL_FRACTION_PART_O(PLL_FRACTION_PART_O));

// file: cap_power_regs_tb.sv
/* self-checking bench for the analog power and pll divider register block.
   drives apb, pll power and master clock pins itself; short ramp count. */
`timescale 1ns/100ps
`include "cap_consts.vh"
module cap_power_regs_tb_top;
    localparam [31:0] ANA = `CAP_IDX_ANA_POWER * 4;
    localparam [31:0] PLL = `CAP_IDX_PLL_DIV * 4;
    localparam [31:0] DIV = 32'h7599; // int 0xE, frac 0x599: 180.6336 MHz from 12.288 MHz
    reg clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, pll_on = 1'b0, mclk = 1'b0, mrun = 1'b0;
    reg [31:0] paddr = 32'h0, pwdata = 32'h0, rd;
    reg err, last;
    int num_errors = 0, n_checks = 0, cycles = 0, flips;
    wire pready, slverr, main, osc, gnd, rup, rdn, adc, adcr, bias, hp, dac, cap, line, refc;
    wire [31:0] prdata;
    wire [4:0] pint;
    wire [10:0] pfrac;
    wire [31:0] pins = {23'h0, main, osc, gnd, bias, hp, dac, cap, adc, line};
    always #4 clk = ~clk;
    cap_power_regs #(.RAMP_CYCLES(16)) cap_power_regs_inst (.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PREADY_O(pready), .PRDATA_O(prdata),
        .PSLVERR_O(slverr), .PLL_ON_I(pll_on), .MCLK_I(mclk), .MAIN_CORE_REGULATOR_ON_O(main), .OSC_AMP_ON_O(osc),
        .GROUND_REF_BUFFER_ON_O(gnd), .RAMP_UP_O(rup), .RAMP_DOWN_O(rdn), .ADC_ON_O(adc), .ADC_RIGHT_ON_O(adcr),
        .BIAS_CURRENT_ON_O(bias), .HEADPHONE_ON_O(hp), .DAC_ON_O(dac), .CAPLESS_HP_ON_O(cap),
        .LINE_OUT_ON_O(line), .PLL_INT_PART_O(pint), .PLL_FRACTION_PART_O(pfrac), .PLL_REF_CLK_O(refc));
    // master clock of four cycles' period; a hang is cut short at 3000 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        mclk <= mrun && cycles[1];
        if (cycles == 3000) begin
            num_errors++;
            final_report;
        end
    end
    task final_report;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one apb transfer; a pready that never comes is caught by the cycle ceiling
    task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = slverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task t_reset;
        apb(0, ANA, 0);
        chk("ana reset", 32'h60, rd);
        chk("ana pins", 32'h20, pins);
        apb(0, PLL, 0);
        chk("pll reset", 32'h5000, rd);
        $display("reset test done");
    endtask
    // walking one over every power bit, upper bits written as ones
    task t_ana;
        logic [31:0] v;
        for (int i = 0; i < 11; i++) begin
            v = (i < 10) ? (32'h1 << i) : 32'h3FF;
            apb(1, ANA, 32'hFFFFFC00 | v);
            apb(0, ANA, 0);
            chk("ana read", v, rd);
            chk("ana pins", {v[9:7], v[5:0]}, pins);
            chk("adc right", v[6] & v[1], adcr);
        end
        $display("power bits test done");
    endtask
    task t_ramp;
        apb(1, ANA, 32'h10);
        apb(1, ANA, 32'h90);
        repeat (3) @(posedge clk);
        chk("ramp up", 1, rup);
        repeat (25) @(posedge clk);
        chk("ramp up end", 0, rup);
        apb(1, ANA, 32'h10);
        repeat (3) @(posedge clk);
        chk("ramp down", 1, rdn);
        apb(0, `CAP_IDX_STATUS * 4, 0);
        chk("status busy down", 32'h1, rd);
        apb(1, `CAP_IDX_STATUS * 4, 32'h7);
        chk("status write err", 1, err);
        repeat (25) @(posedge clk);
        chk("ramp down end", 0, rdn);
        $display("ramp test done");
    endtask
    task t_pll;
        apb(1, PLL, 32'hFFFF0000 | DIV);
        apb(0, PLL, 0);
        chk("pll read", DIV, rd);
        chk("pll fields", DIV, {pint, pfrac});
        pll_on <= 1'b1;
        apb(1, PLL, 32'h1234);
        chk("pll refused", 1, err);
        chk("pll kept", DIV, {pint, pfrac});
        apb(0, 32'h3FC, 0);
        chk("unmapped data", 0, rd);
        chk("unmapped err", 1, err);
        $display("pll divider test done");
    endtask
    // halving only acts with the pll powered: 8 or 16 flips in 32 cycles
    task t_ref;
        mrun <= 1'b1;
        apb(1, `CAP_IDX_CLK_CFG * 4, 32'h8);
        for (int k = 0; k < 2; k++) begin
            pll_on <= (k == 0);
            repeat (12) @(posedge clk);
            flips = 0;
            last = refc;
            repeat (32) begin
                @(posedge clk);
                if (refc !== last) flips++;
                last = refc;
            end
            chk("ref flips", (k == 0) ? 8 : 16, flips);
        end
        $display("reference path test done");
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_ana;
        t_ramp;
        t_pll;
        t_ref;
        final_report;
    end
endmodule // cap_power_regs_tb_top

// file: cap_ref_div.v
/*
 * master clock path into the pll: pass through or halve.
 * assumes the master clock level is already synchronised to CLK_I.
 */
`timescale 1ns/100ps
module cap_ref_div (
    input wire clk_i,
    input wire rst_n_i,
    input wire mclk_i,
    input wire halve_i,
    input wire pll_on_i,
    output reg ref_o
);
    reg mclk_prev;

    // halving only bites while the pll runs; otherwise the level passes through
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            mclk_prev <= 1'b0;
            ref_o <= 1'b0;
        end else begin
            mclk_prev <= mclk_i;
            if (halve_i && pll_on_i) begin // [RULE_17]
                if (mclk_i && !mclk_prev) begin
                    ref_o <= ~ref_o;
                end
            end else begin
                ref_o <= mclk_i;
            end
        end
    end
endmodule // cap_ref_div
